// *** tsiar_pkg.sv ***
package tsiar_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_MODULE_STATUS = 8'h3C;
  localparam logic [7:0] OFS_STATUS_CLEAR = 8'h40;
  localparam logic [7:0] OFS_IRQ_ENABLE_SET = 8'h44;
  localparam logic [7:0] OFS_IRQ_ENABLE_CLEAR = 8'h48;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h4C;
  localparam logic [7:0] OFS_ACQ_SELECT = 8'h50;
  localparam logic [7:0] OFS_ACQ_COUNT = 8'h54;
  // status bit positions
  localparam int BIT_ENABLED = 0;
  localparam int BIT_CALIBRATING = 1;
  localparam int BIT_STATUS_CHANGE = 2;
  localparam int BIT_SENSOR_ACTIVE = 3;
  localparam int BIT_BURST_REQ = 4;
  localparam int BIT_COUNT_READY = 8;
  localparam int BIT_ACQ_COMPLETE = 9;
  localparam int BIT_STATE_WR_REQ = 16;
  localparam int BIT_STATE_RD_READY = 17;
  localparam int BIT_STATE_CHANGED = 23;
  // bits that software may clear, and that may raise the interrupt
  localparam logic [31:0] IRQ_SRC_MASK = 32'h0080_0306;
  localparam logic [31:0] RESET_ZERO = 32'h0000_0000;
  localparam logic [1:0] SEL_RESET = 2'h0;
  // acquired count layout
  localparam int COUNT_LSB = 0;
  localparam int INDEX_LSB = 16;
  localparam int YIDX_LSB = 24;

  typedef enum logic [1:0] {
    TSIAR_SEL_GROUP_A = 2'h0,
    TSIAR_SEL_GROUP_B = 2'h1,
    TSIAR_SEL_MATRIX = 2'h2,
    TSIAR_SEL_UNDEF = 2'h3
  } tsiar_sel_t;

  // one acquired count result from the acquisition engine
  typedef struct packed {
    logic [7:0] y_index;
    logic [7:0] pair_or_row_index;
    logic [15:0] count;
  } tsiar_count_t;

  // events and levels reported by the acquisition engines
  typedef struct packed {
    logic module_enabled;
    logic autonomous_calibrating;
    logic autonomous_status_change;
    logic autonomous_sensor_active;
    logic burst_length_required;
    logic count_valid;
    logic acquisition_complete;
    logic state_word_write_request;
    logic state_word_read_ready;
    logic touch_state_changed;
  } tsiar_evt_t;
endpackage : tsiar_pkg

// *** tsiar_regs.sv ***
// Functional notes
// - status bit 0 shows module enabled.
// - status bit 1 shows calibration; clearable, maskable interrupt source.
// - status bit 2 set on autonomous sensor status change; interrupt source.
// - status bit 3 shows autonomous sensor active.
// - status bit 4 shows matrix acquisition waiting for burst lengths.
// - status bit 8 set when a new count value is available.
// - status bit 9 reads 0 during acquisition, 1 when complete; here it stays set until cleared by a one, a start does not clear it.
// - status bit 16 shows state engine requests a state word write.
// - status bit 17 shows new state word available to read.
// - status bit 23 set when sensor state word bits changed.
// - writing one to status clear clears bits 23, 9, 8, 2, 1.
// - zero bits written to clear, enable, disable registers change nothing.
// - writing one to enable register sets the matching mask bit.
// - writing one to disable register clears the matching mask bit.
// - mask register reads enabled sources, resets to zero.
// - any select register write starts acquisition of the selected type.
// - select register reads back the last written selector, reset zero.
// - count register holds count 15:0, pair/X 23:16, Y 31:24.
// - touch group results carry Y zero, rising pair index.
// - matrix results step Y for each X, then advance X.
//
// Local design decision: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module tsiar_regs (
  input wire logic MCLK,
  input wire logic RESET_N,
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  input wire tsiar_pkg::tsiar_evt_t EVT,
  input wire tsiar_pkg::tsiar_count_t COUNT_IN,
  output logic ACQ_START,
  output tsiar_pkg::tsiar_sel_t ACQ_SEL,
  output logic IRQ
);
  import tsiar_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // address decode; an exact byte match, so a misaligned offset hits nothing
  function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] o);
    return a == o;
  endfunction : addr_hit
  logic wr_clear, wr_ien, wr_idis, wr_sel;
  logic rd_status, rd_mask, rd_sel, rd_count;
  assign wr_clear = WR && addr_hit(ADDR, OFS_STATUS_CLEAR);
  assign wr_ien = WR && addr_hit(ADDR, OFS_IRQ_ENABLE_SET);
  assign wr_idis = WR && addr_hit(ADDR, OFS_IRQ_ENABLE_CLEAR);
  assign wr_sel = WR && addr_hit(ADDR, OFS_ACQ_SELECT);
  // read decodes feed only the checks below; the read mux keys on ADDR
  assign rd_status = RD && addr_hit(ADDR, OFS_MODULE_STATUS);
  assign rd_mask = RD && addr_hit(ADDR, OFS_IRQ_MASK);
  assign rd_sel = RD && addr_hit(ADDR, OFS_ACQ_SELECT);
  assign rd_count = RD && addr_hit(ADDR, OFS_ACQ_COUNT);

  ////////////////////////////////////////////////////////////////////////////
  // sticky status flags; a set in the clearing cycle wins
  logic [31:0] sticky_r, sticky_nxt, set_vec, clr_vec;
  always_comb begin
    set_vec = RESET_ZERO;
    set_vec[BIT_CALIBRATING] = EVT.autonomous_calibrating;
    set_vec[BIT_STATUS_CHANGE] = EVT.autonomous_status_change;
    set_vec[BIT_COUNT_READY] = EVT.count_valid;
    set_vec[BIT_ACQ_COMPLETE] = EVT.acquisition_complete;
    set_vec[BIT_STATE_CHANGED] = EVT.touch_state_changed;
  end
  assign clr_vec = wr_clear ? (WDATA & IRQ_SRC_MASK) : RESET_ZERO;
  assign sticky_nxt = ((sticky_r & ~clr_vec) | set_vec) & IRQ_SRC_MASK;
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      sticky_r <= RESET_ZERO;
    end else begin
      sticky_r <= sticky_nxt;
    end
  end

  // sticky checks: clear by one, set beats clear, zeros and idle hold
  property p_clear_works;
    @(posedge MCLK) disable iff (!RESET_N)
    (wr_clear && WDATA[BIT_ACQ_COMPLETE] && !EVT.acquisition_complete)
      |=> !sticky_r[BIT_ACQ_COMPLETE];
  endproperty
  a_clear_works: assert property (p_clear_works)
    else $error("clear lost");

  property p_set_wins;
    @(posedge MCLK) disable iff (!RESET_N)
    EVT.touch_state_changed |=> sticky_r[BIT_STATE_CHANGED];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("set lost");

  property p_zero_keeps;
    @(posedge MCLK) disable iff (!RESET_N)
    (wr_clear && WDATA == RESET_ZERO && sticky_r[BIT_STATUS_CHANGE])
      |=> sticky_r[BIT_STATUS_CHANGE];
  endproperty
  a_zero_keeps: assert property (p_zero_keeps)
    else $error("zero cleared");

  property p_calib_sets;
    @(posedge MCLK) disable iff (!RESET_N)
    EVT.autonomous_calibrating |=> sticky_r[BIT_CALIBRATING];
  endproperty
  a_calib_sets: assert property (p_calib_sets)
    else $error("calibration lost");

  // a change flag stays up until software clears it
  property p_change_holds;
    @(posedge MCLK) disable iff (!RESET_N)
    (sticky_r[BIT_STATUS_CHANGE] && !(wr_clear && WDATA[BIT_STATUS_CHANGE]))
      |=> sticky_r[BIT_STATUS_CHANGE];
  endproperty
  a_change_holds: assert property (p_change_holds)
    else $error("change flag dropped");

  // completion is sticky so a short done pulse is never missed
  property p_done_sets;
    @(posedge MCLK) disable iff (!RESET_N)
    EVT.acquisition_complete |=> sticky_r[BIT_ACQ_COMPLETE];
  endproperty
  a_done_sets: assert property (p_done_sets)
    else $error("done flag lost");

  ////////////////////////////////////////////////////////////////////////////
  // interrupt mask
  logic [31:0] mask_r, mask_nxt;
  assign mask_nxt = ((mask_r | (wr_ien ? WDATA : RESET_ZERO))
                    & ~(wr_idis ? WDATA : RESET_ZERO)) & IRQ_SRC_MASK;
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      mask_r <= RESET_ZERO;
    end else begin
      mask_r <= mask_nxt;
    end
  end
  assign IRQ = |(sticky_r & mask_r);

  // mask checks; enable and disable never share a cycle on this bus
  property p_ien;
    @(posedge MCLK) disable iff (!RESET_N)
    (wr_ien && WDATA[BIT_COUNT_READY]) |=> mask_r[BIT_COUNT_READY];
  endproperty
  a_ien: assert property (p_ien) else $error("enable failed");

  property p_idis;
    @(posedge MCLK) disable iff (!RESET_N)
    (wr_idis && WDATA[BIT_COUNT_READY] && !wr_ien)
      |=> !mask_r[BIT_COUNT_READY];
  endproperty
  a_idis: assert property (p_idis) else $error("disable failed");

  property p_mask_zero;
    @(posedge MCLK) disable iff (!RESET_N)
    ((wr_ien || wr_idis) && WDATA == RESET_ZERO) |=> $stable(mask_r);
  endproperty
  a_mask_zero: assert property (p_mask_zero)
    else $error("zero write moved mask");

  property p_irq;
    @(posedge MCLK) disable iff (!RESET_N)
    (sticky_r[BIT_ACQ_COMPLETE] && mask_r[BIT_ACQ_COMPLETE]) |-> IRQ;
  endproperty
  a_irq: assert property (p_irq) else $error("irq missing");

  // with every source masked the line must stay low, whatever is pending
  property p_irq_quiet;
    @(posedge MCLK) disable iff (!RESET_N)
    (mask_r == RESET_ZERO) |-> !IRQ;
  endproperty
  a_irq_quiet: assert property (p_irq_quiet) else $error("irq leaked");

  ////////////////////////////////////////////////////////////////////////////
  // acquisition select and start pulse
  logic [1:0] sel_r;
  logic start_r;
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      sel_r <= SEL_RESET;
      start_r <= 1'b0;
    end else begin
      start_r <= wr_sel;
      if (wr_sel) begin
        sel_r <= WDATA[1:0];
      end
    end
  end
  assign ACQ_START = start_r;
  assign ACQ_SEL = tsiar_sel_t'(sel_r);

  // a select write answers with the new selector and one start pulse;
  // a second write right behind it keeps the pulse up one more cycle
  sequence s_sel_write;
    wr_sel;
  endsequence
  sequence s_start_answer;
    ACQ_START ##1 (ACQ_START == $past(wr_sel));
  endsequence
  property p_start;
    @(posedge MCLK) disable iff (!RESET_N)
    s_sel_write |=> (ACQ_SEL == $past(WDATA[1:0])) ##0 s_start_answer;
  endproperty
  a_start: assert property (p_start) else $error("start wrong");

  ////////////////////////////////////////////////////////////////////////////
  // count capture; engine delivers results in scan order
  // touch order
  logic [31:0] count_r;
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      count_r <= RESET_ZERO;
    end else if (EVT.count_valid) begin
      count_r <= COUNT_IN;
    end
  end

  // capture keeps the engine's field order untouched
  property p_count;
    @(posedge MCLK) disable iff (!RESET_N)
    EVT.count_valid |=> count_r == $past(COUNT_IN)
      && sticky_r[BIT_COUNT_READY];
  endproperty
  a_count: assert property (p_count) else $error("count wrong");

  // field positions checked one by one, so a swapped pair is caught
  property p_count_layout;
    @(posedge MCLK) disable iff (!RESET_N)
    EVT.count_valid |=>
      (count_r[COUNT_LSB +: 16] == $past(COUNT_IN.count))
      && (count_r[INDEX_LSB +: 8] == $past(COUNT_IN.pair_or_row_index))
      && (count_r[YIDX_LSB +: 8] == $past(COUNT_IN.y_index));
  endproperty
  a_count_layout: assert property (p_count_layout)
    else $error("count fields misplaced");

  ////////////////////////////////////////////////////////////////////////////
  // status word; level bits follow the engines directly
  logic [31:0] status_w;
  always_comb begin
    status_w = sticky_r;
    status_w[BIT_ENABLED] = EVT.module_enabled;
    status_w[BIT_CALIBRATING] = sticky_r[BIT_CALIBRATING];
    status_w[BIT_SENSOR_ACTIVE] = EVT.autonomous_sensor_active;
    status_w[BIT_BURST_REQ] = EVT.burst_length_required;
    status_w[BIT_STATE_WR_REQ] = EVT.state_word_write_request;
    status_w[BIT_STATE_RD_READY] = EVT.state_word_read_ready;
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux, registered; unmapped and write-only offsets read zero
  logic [31:0] rd_mux, rdata_r;
  always_comb begin
    unique case (ADDR)
      OFS_MODULE_STATUS: rd_mux = status_w;
      OFS_IRQ_MASK: rd_mux = mask_r;
      OFS_ACQ_SELECT: rd_mux = {30'h0000_0000, sel_r};
      OFS_ACQ_COUNT: rd_mux = count_r;
      default: rd_mux = RESET_ZERO;
    endcase
  end
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rdata_r <= RESET_ZERO;
    end else begin
      rdata_r <= RD ? rd_mux : RESET_ZERO;
    end
  end
  assign RDATA = rdata_r;

  // read answers: each readable word stands only in the cycle after RD
  property p_enabled;
    @(posedge MCLK) disable iff (!RESET_N)
    rd_status |=> RDATA[BIT_ENABLED] == $past(EVT.module_enabled);
  endproperty
  a_enabled: assert property (p_enabled) else $error("enabled wrong");

  property p_active;
    @(posedge MCLK) disable iff (!RESET_N)
    rd_status
      |=> RDATA[BIT_SENSOR_ACTIVE] == $past(EVT.autonomous_sensor_active);
  endproperty
  a_active: assert property (p_active) else $error("active wrong");

  property p_burst;
    @(posedge MCLK) disable iff (!RESET_N)
    rd_status
      |=> RDATA[BIT_BURST_REQ] == $past(EVT.burst_length_required);
  endproperty
  a_burst: assert property (p_burst) else $error("burst wrong");

  property p_wr_req;
    @(posedge MCLK) disable iff (!RESET_N)
    rd_status
      |=> RDATA[BIT_STATE_WR_REQ] == $past(EVT.state_word_write_request);
  endproperty
  a_wr_req: assert property (p_wr_req) else $error("write req wrong");

  property p_rd_ready;
    @(posedge MCLK) disable iff (!RESET_N)
    rd_status
      |=> RDATA[BIT_STATE_RD_READY] == $past(EVT.state_word_read_ready);
  endproperty
  a_rd_ready: assert property (p_rd_ready)
    else $error("read ready wrong");

  property p_mask_read;
    @(posedge MCLK) disable iff (!RESET_N)
    rd_mask |=> RDATA == $past(mask_r);
  endproperty
  a_mask_read: assert property (p_mask_read) else $error("mask read");

  property p_sel_read;
    @(posedge MCLK) disable iff (!RESET_N)
    rd_sel |=> RDATA == {30'h0000_0000, $past(sel_r)};
  endproperty
  a_sel_read: assert property (p_sel_read) else $error("select read");

  property p_count_read;
    @(posedge MCLK) disable iff (!RESET_N)
    rd_count |=> RDATA == $past(count_r);
  endproperty
  a_count_read: assert property (p_count_read)
    else $error("count read");
endmodule : tsiar_regs
`default_nettype wire

// *** tb_touch_status_irq_acq_regs.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_touch_status_irq_acq_regs;
  import tsiar_pkg::*;
  logic mclk = 1'b0;
  logic reset_n, wr, rd, irq, acq_start;
  logic [7:0] addr;
  logic [31:0] wdata, rdata;
  tsiar_evt_t evt;
  tsiar_count_t cnt_in;
  tsiar_sel_t acq_sel;
  int failures = 0;
  int n_compared = 0;
  // status position of each event field, field index is 9 minus entry
  int sp[10] = '{0, 1, 2, 3, 4, 8, 9, 16, 17, 23};
  // group results first, then matrix results in x-major order
  logic [31:0] seq[7] = '{32'h0001_1111, 32'h0004_2222, 32'h0009_3333,
    32'h0402_4444, 32'h0702_5555, 32'h0403_6666, 32'h0703_7777};

  tsiar_regs DUT (.MCLK(mclk), .RESET_N(reset_n), .ADDR(addr),
    .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .EVT(evt),
    .COUNT_IN(cnt_in), .ACQ_START(acq_start), .ACQ_SEL(acq_sel),
    .IRQ(irq));

  initial forever #12.5 mclk = ~mclk;

  ////////////////////////////////////////////////////////////////////////////
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask : chk

  // ends 1 ns after the edge that took the write, effects already settled
  task wrr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
    #1;
  endtask : wrr

  // read data stands only in the cycle after the strobe
  task rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    chk(nm, e, rdata);
  endtask : rdc

  task end_sim;
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_sim

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    reset_n = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    evt = '0;
    cnt_in = '0;
    repeat (2) @(posedge mclk);
    reset_n <= 1'b1;
    // reset values, write-only and unmapped places read zero
    rdc(OFS_MODULE_STATUS, RESET_ZERO, "status");
    rdc(OFS_IRQ_MASK, RESET_ZERO, "mask");
    rdc(OFS_ACQ_SELECT, RESET_ZERO, "select");
    rdc(OFS_ACQ_COUNT, RESET_ZERO, "count");
    rdc(OFS_STATUS_CLEAR, RESET_ZERO, "clear reg");
    rdc(8'h5C, RESET_ZERO, "unmapped");
    wrr(OFS_IRQ_MASK, 32'hFFFF_FFFF);
    rdc(OFS_IRQ_MASK, RESET_ZERO, "mask ro");
    for (int k = 0; k < 10; k++) begin
      @(posedge mclk);
      evt[9-k] <= 1'b1;
      if (IRQ_SRC_MASK[sp[k]]) begin
        @(posedge mclk);
        evt[9-k] <= 1'b0;
      end
      if (sp[k] == BIT_BURST_REQ) begin
        wrr(8'h58, 32'h0101_0101);
      end
      rdc(OFS_MODULE_STATUS, 32'h1 << sp[k], "status bit");
      wrr(OFS_STATUS_CLEAR, ~IRQ_SRC_MASK);
      rdc(OFS_MODULE_STATUS, 32'h1 << sp[k], "zero clear");
      wrr(OFS_STATUS_CLEAR, 32'h1 << sp[k]);
      rdc(OFS_MODULE_STATUS, IRQ_SRC_MASK[sp[k]] ? 32'h0 : 32'h1 << sp[k],
        "after clear");
      @(posedge mclk);
      evt <= '0;
    end
    // results read back in arrival order
    for (int i = 0; i < 7; i++) begin
      @(posedge mclk);
      cnt_in <= seq[i];
      evt.count_valid <= 1'b1;
      @(posedge mclk);
      evt <= '0;
      rdc(OFS_ACQ_COUNT, seq[i], "count");
    end
    wrr(OFS_STATUS_CLEAR, IRQ_SRC_MASK);
    wrr(OFS_IRQ_ENABLE_SET, 32'hFFFF_FFFF);
    rdc(OFS_IRQ_MASK, IRQ_SRC_MASK, "mask set");
    wrr(OFS_IRQ_ENABLE_CLEAR, 32'h0000_0004);
    wrr(OFS_IRQ_ENABLE_SET, 32'h0);
    wrr(OFS_IRQ_ENABLE_CLEAR, 32'h0);
    rdc(OFS_IRQ_MASK, IRQ_SRC_MASK & ~32'h4, "mask clr");
    // masked source stays quiet, enabled source raises the line
    @(posedge mclk);
    evt.autonomous_status_change <= 1'b1;
    @(posedge mclk);
    evt <= '0;
    #1;
    chk("irq masked", 32'h0, irq);
    @(posedge mclk);
    evt.acquisition_complete <= 1'b1;
    @(posedge mclk);
    evt <= '0;
    #1;
    chk("irq done", 32'h1, irq);
    wrr(OFS_STATUS_CLEAR, 32'h0000_0200);
    chk("irq cleared", 32'h0, irq);
    wrr(OFS_IRQ_ENABLE_SET, 32'h0000_0004);
    chk("irq enabled", 32'h1, irq);
    wrr(OFS_IRQ_ENABLE_CLEAR, 32'h0000_0004);
    chk("irq disabled", 32'h0, irq);
    // selectors 2, 1 and 0 each start an acquisition and read back
    for (int s = 2; s >= 0; s--) begin
      wrr(OFS_ACQ_SELECT, 32'(s));
      chk("start", 32'h1, acq_start);
      chk("sel", 32'(s), acq_sel);
      @(posedge mclk);
      #1;
      chk("start end", 32'h0, acq_start);
      rdc(OFS_ACQ_SELECT, 32'(s), "select");
    end
    end_sim();
  end
endmodule : tb_touch_status_irq_acq_regs
`default_nettype wire
